// ===== usf_ctrl.sv
// control, status, interrupt, baud and driver-enable logic of the serial port
`timescale 1ns/1ps
// What this block does
// R1: modem status top bits show inverted pins, or handshake bits 3,2,0,1 in loopback.
// R2: carrier, set-ready, clear-send change flags set on any change since last read.
// R3: ring edge flag sets when ring input pin rises since last read.
// R4: fifo control bits 7:6 pick receive trigger 1, 4, 8 or 14 bytes.
// R5: fifo control bits 2 and 1 reset transmit and receive counters, self-clearing.
// R6: fifo control bit 0 enables fifo mode; software sets it first.
// R7: fifo control bit 3 selects dma mode 1 only with fifo enabled.
// R8: identification bits 7:6 read ones in fifo mode, else zeros.
// R9: identification bit 0 high with nothing pending; resets to no-interrupt code.
// R10: line errors report 0110 at top priority; line status read clears.
// R11: receive ready or trigger reports 0100; cleared by reading data below trigger.
// R12: fifo data idle four character times reports 1100; receive read clears.
// R13: empty transmit buffer reports 0010; data write or identification read clears.
// R14: any modem change flag reports 0000 lowest; modem status read clears.
// R15: identification bit 3 stays zero unless fifo mode enabled.
// R16: enable bits 0..3 gate receive, transmit, line and modem interrupts.
// R17: in nine-bit mode enable bit 7 selects address or data transmit byte.
// R18: in nine-bit mode enable bit 6 selects address or data receive.
// R19: baud divider divides base clock by 16-bit divisor giving 16x rate.
// R20: base clock is reference over 13, 1.625 or 1 per configuration.
// R21: auto driver enable rises at start-to-bit0 edge, falls 1-2 bits after stop.
// R22: polarity configuration bit inverts the automatic driver enable levels.
// R23: interrupt output driven only with handshake bit 3; loopback feeds carrier.
// R24: identification shows top enabled pending source; output holds while any pend.
module usf_ctrl
   import usf_pkg::*;
(
   input  wire logic       clk,               // 250 MHz clock
   input  wire logic       rst_n,             // async reset
   input  wire logic [2:0] addr,              // register offset
   input  wire logic [7:0] wdata,             // write data
   input  wire logic       wr_stb,            // write strobe
   input  wire logic       rd_stb,            // read strobe
   output logic      [7:0] rdata,             // read data, valid after strobe
   input  wire usf_cfg_t   cfg,               // port configuration bits
   input  wire logic [7:0] rx_data_i,         // head of receive fifo
   input  wire logic [4:0] rx_level_i,        // receive fill level
   input  wire logic       rx_ready_i,        // receive data ready
   input  wire logic       rx_push_i,         // byte entered receive fifo
   input  wire logic [7:0] line_status_i,     // line status byte
   input  wire usf_lsev_t  ls_ev_i,           // line error pulses
   input  wire logic       tx_start_edge_i,   // start to bit0 edge
   input  wire logic       tx_stop_done_i,    // stop bit finished
   input  wire logic       tx_ready_i,        // transmitter takes word
   output logic      [7:0] tx_data_o,         // word to transmitter
   output logic            tx_valid_o,        // word available
   output logic            tx_buf_ready_o,    // buffer can accept a write
   output logic            rx_pop_o,          // receive buffer read pulse
   output logic            tx_fifo_rst_o,     // transmit counter reset pulse
   output logic            rx_fifo_rst_o,     // receive counter reset pulse
   output logic            dma_mode1_o,       // dma mode 1 selected
   output logic            tx_addr_byte_o,    // send address byte
   output logic            rx_addr_accept_o,  // accept address bytes
   output logic            baud16_tick_o,     // 16x bit rate enable
   output logic            loopback_o,        // diagnostic loopback
   output logic            irq_o,             // interrupt output
   output logic            dtr_n_o,           // terminal ready pin
   output logic            rts_n_o,           // request to send pin
   input  wire logic       dcd_n,             // carrier detect pin
   input  wire logic       ri_n,              // ring pin
   input  wire logic       dsr_n,             // set ready pin
   input  wire logic       cts_n              // clear to send pin
);

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0]    ier_reg, hcr_reg, fcr_reg, lcr_reg, scr_reg, isr_reg;
   logic [15:0]   div_reg;
   logic [3:0]    delta_reg, st_reg;
   logic          ls_pend_reg, tx_pend_reg, to_pend_reg, empty_d_reg;
   logic [9:0]    to_cnt_reg;
   logic [15:0]   acc_reg, bcnt_reg;
   logic          base_tick;
   logic [7:0]    tb0_reg, tb1_reg;
   logic [1:0]    tb_cnt_reg;
   usf_de_state_t de_reg;
   logic [5:0]    de_cnt_reg;

   function automatic logic [4:0] trig_of(input logic [1:0] sel);
      unique case (sel)
         2'b00: trig_of = TRIG_L0;
         2'b01: trig_of = TRIG_L1;
         2'b10: trig_of = TRIG_L2;
         2'b11: trig_of = TRIG_L3;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // address decode
   wire dlab     = lcr_reg[LCR_DLAB];
   wire wr_thr   = wr_stb && addr == OFS_DATA && !dlab;
   wire wr_dll   = wr_stb && addr == OFS_DATA && dlab;
   wire wr_ier   = wr_stb && addr == OFS_IER && !dlab;
   wire wr_dlh   = wr_stb && addr == OFS_IER && dlab;
   wire wr_fcr   = wr_stb && addr == OFS_ISR;
   wire wr_lcr   = wr_stb && addr == OFS_LCR;
   wire wr_hcr   = wr_stb && addr == OFS_HCR;
   wire wr_scr   = wr_stb && addr == OFS_SCR;
   wire rd_rbr   = rd_stb && addr == OFS_DATA && !dlab;
   wire rd_isr   = rd_stb && addr == OFS_ISR;
   wire rd_lsr   = rd_stb && addr == OFS_LSR;
   wire rd_msr   = rd_stb && addr == OFS_MSR;
   wire fifo_en  = fcr_reg[FCR_EN];
   wire loop     = hcr_reg[HCR_LOOP];

   ////////////////////////////////////////////////////////////////////////
   // modem status
   wire [3:0] st_next = loop ? {hcr_reg[HCR_IRQEN], hcr_reg[HCR_RI],
                                hcr_reg[HCR_DTR], hcr_reg[HCR_RTS]}
                             : ~{dcd_n, ri_n, dsr_n, cts_n}; // R1 R23
   wire [3:0] chg = st_next ^ st_reg;
   wire [3:0] delta_set = {chg[3], st_reg[2] & ~st_next[2], chg[1], chg[0]}; // R2 R3
   wire [3:0] delta_next = (rd_msr ? 4'h0 : delta_reg) | delta_set;
   wire [7:0] msr_val = {st_reg, delta_reg};

   ////////////////////////////////////////////////////////////////////////
   // interrupt sources and priority
   wire [4:0] trig     = trig_of(fcr_reg[7:6]); // R4
   wire rx_avail = fifo_en ? (rx_level_i >= trig) : rx_ready_i; // R11
   wire ls_ev    = |ls_ev_i;
   wire ls_on    = ls_pend_reg && ier_reg[IER_LS]; // R16
   wire rx_on    = rx_avail && ier_reg[IER_RX];
   wire to_on    = to_pend_reg && fifo_en && ier_reg[IER_RX];
   wire tx_on    = tx_pend_reg && ier_reg[IER_TX];
   wire ms_on    = (|delta_reg) && ier_reg[IER_MS];
   wire [3:0] id_next = ls_on ? ID_LS
                      : rx_on ? ID_RX
                      : to_on ? ID_TO
                      : tx_on ? ID_TX
                      : ms_on ? ID_MS : ID_NONE; // R24 R10 R11 R12 R13 R14
   wire [7:0] isr_next = {{2{fifo_en}}, 2'b00, id_next[3] & fifo_en, id_next[2:0]}; // R8 R9 R15
   wire any_on = !id_next[0];

   wire tb_empty  = tb_cnt_reg == 2'd0;
   wire tx_done   = wr_thr && tb_cnt_reg != 2'd2;
   wire tx_taken  = tx_ready_i && tb_cnt_reg != 2'd0;
   wire tx_rise   = tb_empty && !empty_d_reg;
   wire tx_clr    = wr_thr || (rd_isr && isr_reg[3:0] == ID_TX); // R13
   wire to_hit    = baud16_tick_o && to_cnt_reg == TO_TICKS - 10'd1;
   wire to_run    = fifo_en && rx_level_i != 5'd0 && !to_pend_reg;

   ////////////////////////////////////////////////////////////////////////
   // register writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ier_reg <= IER_RST;
         hcr_reg <= HCR_RST;
         fcr_reg <= FCR_RST;
         lcr_reg <= LCR_RST;
         scr_reg <= SCR_RST;
         div_reg <= DIV_RST;
      end else begin
         if (wr_ier) ier_reg <= wdata & 8'hCF;
         if (wr_hcr) hcr_reg <= wdata & 8'h1F;
         if (wr_fcr) fcr_reg <= wdata & 8'hC9; // R6 R5
         if (wr_lcr) lcr_reg <= wdata;
         if (wr_scr) scr_reg <= wdata;
         if (wr_dll) div_reg[7:0] <= wdata;
         if (wr_dlh) div_reg[15:8] <= wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status flags, set wins over clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg      <= 4'h0;
         delta_reg   <= 4'h0;
         ls_pend_reg <= 1'b0;
         tx_pend_reg <= 1'b0;
         to_pend_reg <= 1'b0;
         empty_d_reg <= 1'b1;
         to_cnt_reg  <= 10'd0;
         isr_reg     <= ISR_RST;
      end else begin
         st_reg      <= st_next;
         delta_reg   <= delta_next; // R2 R3 R14
         ls_pend_reg <= ls_ev || (ls_pend_reg && !rd_lsr); // R10
         tx_pend_reg <= tx_rise || (tx_pend_reg && !tx_clr); // R13
         empty_d_reg <= tb_empty;
         isr_reg     <= isr_next; // R24
         if (rd_rbr || rx_push_i || !to_run)
            to_cnt_reg <= 10'd0;
         else if (baud16_tick_o)
            to_cnt_reg <= to_cnt_reg + 10'd1;
         to_pend_reg <= (to_run && to_hit) || (to_pend_reg && !rd_rbr && fifo_en); // R12
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read port and strobe outputs
   wire [7:0] rd_mux = addr == OFS_DATA ? (dlab ? div_reg[7:0] : rx_data_i)
                     : addr == OFS_IER  ? (dlab ? div_reg[15:8] : ier_reg)
                     : addr == OFS_ISR  ? isr_reg
                     : addr == OFS_LCR  ? lcr_reg
                     : addr == OFS_HCR  ? hcr_reg
                     : addr == OFS_LSR  ? line_status_i
                     : addr == OFS_MSR  ? msr_val : scr_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata            <= 8'h00;
         rx_pop_o         <= 1'b0;
         tx_fifo_rst_o    <= 1'b0;
         rx_fifo_rst_o    <= 1'b0;
         dma_mode1_o      <= 1'b0;
         tx_addr_byte_o   <= 1'b0;
         rx_addr_accept_o <= 1'b0;
         loopback_o       <= 1'b0;
         irq_o            <= 1'b0;
         dtr_n_o          <= 1'b1;
      end else begin
         if (rd_stb) rdata <= rd_mux;
         rx_pop_o         <= rd_rbr;
         tx_fifo_rst_o    <= wr_fcr && wdata[FCR_TXRST]; // R5
         rx_fifo_rst_o    <= wr_fcr && wdata[FCR_RXRST]; // R5
         dma_mode1_o      <= fcr_reg[FCR_DMA] && fifo_en; // R7
         tx_addr_byte_o   <= cfg.nine_bit_en && ier_reg[IER_TXADDR]; // R17
         rx_addr_accept_o <= cfg.nine_bit_en && ier_reg[IER_RXADDR]; // R18
         loopback_o       <= loop;
         irq_o            <= any_on && hcr_reg[HCR_IRQEN]; // R23 R24
         dtr_n_o          <= loop | ~hcr_reg[HCR_DTR];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // two-entry transmit buffer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tb0_reg    <= 8'h00;
         tb1_reg    <= 8'h00;
         tb_cnt_reg <= 2'd0;
      end else if (tx_fifo_rst_o) begin
         tb_cnt_reg <= 2'd0;
      end else begin
         unique case ({tx_done, tx_taken})
            2'b10: begin
               if (tb_cnt_reg == 2'd0) tb0_reg <= wdata;
               else tb1_reg <= wdata;
               tb_cnt_reg <= tb_cnt_reg + 2'd1;
            end
            2'b01: begin
               tb0_reg    <= tb1_reg;
               tb_cnt_reg <= tb_cnt_reg - 2'd1;
            end
            2'b11: begin
               if (tb_cnt_reg == 2'd1) tb0_reg <= wdata;
               else begin
                  tb0_reg <= tb1_reg;
                  tb1_reg <= wdata;
               end
            end
            2'b00: ;
         endcase
      end
   end
   assign tx_data_o      = tb0_reg;
   assign tx_valid_o     = !tb_empty;
   assign tx_buf_ready_o = tb_cnt_reg != 2'd2;

   ////////////////////////////////////////////////////////////////////////
   // baud generator: fractional pre-divider then 16-bit divisor
   wire [15:0] pre_x8 = cfg.clock_predivider_cfg == 2'd0 ? 16'(PRE_13_X8)
                      : cfg.clock_predivider_cfg == 2'd1 ? 16'(PRE_1625_X8)
                      : 16'(PRE_1_X8); // R20
   wire [15:0] acc_lim = 16'(CLK_MHZ) * pre_x8;
   wire [15:0] acc_sum = acc_reg + ACC_INC;
   assign base_tick = acc_sum >= acc_lim;
   wire [15:0] div_eff = div_reg == 16'h0000 ? 16'h0001 : div_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_reg       <= 16'h0000;
         bcnt_reg      <= 16'h0000;
         baud16_tick_o <= 1'b0;
      end else begin
         acc_reg       <= base_tick ? acc_sum - acc_lim : acc_sum; // R20
         baud16_tick_o <= base_tick && bcnt_reg >= div_eff - 16'h0001; // R19
         if (base_tick)
            bcnt_reg <= bcnt_reg >= div_eff - 16'h0001 ? 16'h0000 : bcnt_reg + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // automatic driver enable on request to send
   wire de_pol  = cfg.auto_driver_polarity_cfg;
   wire de_act  = de_reg != DE_IDLE;
   wire rts_man = loop | ~hcr_reg[HCR_RTS];
   wire rts_next = cfg.auto_driver_enable ? (de_act ^ de_pol) : rts_man; // R21 R22

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         de_reg     <= DE_IDLE;
         de_cnt_reg <= 6'd0;
         rts_n_o    <= 1'b1;
      end else begin
         rts_n_o <= rts_next;
         unique case (de_reg)
            DE_IDLE:  if (tx_start_edge_i && cfg.auto_driver_enable) de_reg <= DE_DRIVE; // R21
            DE_DRIVE: if (tx_stop_done_i) begin
               de_reg     <= DE_HOLD;
               de_cnt_reg <= 6'd0;
            end
            DE_HOLD: begin
               if (tx_start_edge_i) de_reg <= DE_DRIVE;
               else if (baud16_tick_o) begin
                  de_cnt_reg <= de_cnt_reg + 6'd1;
                  if (de_cnt_reg == DE_HOLD_TICKS - 6'd1) de_reg <= DE_IDLE; // R21
               end
            end
            default: de_reg <= DE_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   irq_gate_a: assert property (irq_o |-> $past(hcr_reg[HCR_IRQEN])) // R23
      else $error("interrupt driven without enable bit");
   fifo_flag_a: assert property (##1 isr_reg[7:6] == {2{$past(fifo_en)}}) // R8
      else $error("fifo flags wrong in identification");
   bit3_zero_a: assert property (!$past(fifo_en) |-> !isr_reg[3]) // R15
      else $error("identification bit 3 set outside fifo mode");
   cts_change_a: assert property (st_reg[0] != $past(st_reg[0]) |-> delta_reg[0]) // R2
      else $error("clear-send change flag missed");
   ring_edge_a: assert property ($fell(st_reg[2]) |-> delta_reg[2]) // R3
      else $error("ring edge flag missed");
   fifo_rst_a: assert property (wr_fcr && wdata[FCR_TXRST] |=> tx_fifo_rst_o ##1 !tx_fifo_rst_o) // R5
      else $error("transmit reset not a single pulse");
   ls_prio_a: assert property (ls_pend_reg && ier_reg[IER_LS] |=> isr_reg[3:0] == ID_LS) // R10
      else $error("line status not top priority");
   none_code_a: assert property (isr_reg[0] == 1'b1 |-> isr_reg[3:1] == 3'b000) // R9
      else $error("pending code with no-interrupt bit");
   de_drive_a: assert property (cfg.auto_driver_enable && de_reg == DE_DRIVE
                                |=> rts_n_o == !de_pol) // R21 R22
      else $error("driver enable level wrong while sending");
   dma_gate_a: assert property (dma_mode1_o |-> $past(fifo_en)) // R7
      else $error("dma mode 1 without fifo mode");

endmodule // usf_ctrl

// ===== usf_pkg.sv
// shared constants and types for the serial port control block
package usf_pkg;
   // register offsets
   localparam logic [2:0] OFS_DATA  = 3'h0;
   localparam logic [2:0] OFS_IER   = 3'h1;
   localparam logic [2:0] OFS_ISR   = 3'h2;
   localparam logic [2:0] OFS_LCR   = 3'h3;
   localparam logic [2:0] OFS_HCR   = 3'h4;
   localparam logic [2:0] OFS_LSR   = 3'h5;
   localparam logic [2:0] OFS_MSR   = 3'h6;
   localparam logic [2:0] OFS_SCR   = 3'h7;
   // field positions
   localparam int LCR_DLAB      = 7;
   localparam int HCR_DTR       = 0;
   localparam int HCR_RTS       = 1;
   localparam int HCR_RI        = 2;
   localparam int HCR_IRQEN     = 3;
   localparam int HCR_LOOP      = 4;
   localparam int FCR_EN        = 0;
   localparam int FCR_RXRST     = 1;
   localparam int FCR_TXRST     = 2;
   localparam int FCR_DMA       = 3;
   localparam int IER_RX        = 0;
   localparam int IER_TX        = 1;
   localparam int IER_LS        = 2;
   localparam int IER_MS        = 3;
   localparam int IER_RXADDR    = 6;
   localparam int IER_TXADDR    = 7;
   // reset values
   localparam logic [7:0] ISR_RST = 8'h01;
   localparam logic [7:0] IER_RST = 8'h00;
   localparam logic [7:0] HCR_RST = 8'h00;
   localparam logic [7:0] FCR_RST = 8'h00;
   localparam logic [7:0] LCR_RST = 8'h00;
   localparam logic [7:0] SCR_RST = 8'h00;
   localparam logic [15:0] DIV_RST = 16'h0001;
   // identification codes
   localparam logic [3:0] ID_NONE = 4'h1;
   localparam logic [3:0] ID_LS   = 4'h6;
   localparam logic [3:0] ID_RX   = 4'h4;
   localparam logic [3:0] ID_TO   = 4'hC;
   localparam logic [3:0] ID_TX   = 4'h2;
   localparam logic [3:0] ID_MS   = 4'h0;
   // receive trigger levels in bytes
   localparam logic [4:0] TRIG_L0 = 5'h01;
   localparam logic [4:0] TRIG_L1 = 5'h04;
   localparam logic [4:0] TRIG_L2 = 5'h08;
   localparam logic [4:0] TRIG_L3 = 5'h0E;
   // clock rates in MHz, pre-dividers scaled by eight
   localparam int CLK_MHZ = 250;
   localparam int REF_MHZ = 24;
   localparam int PRE_SCALE = 8;
   localparam int PRE_13_X8 = 104;
   localparam int PRE_1625_X8 = 13;
   localparam int PRE_1_X8 = 8;
   localparam logic [15:0] ACC_INC = 16'(REF_MHZ * PRE_SCALE);
   // character timing in 16x ticks
   localparam int TICKS_PER_BIT = 16;
   localparam int BITS_PER_CHAR = 10;
   localparam int TO_CHARS = 4;
   localparam logic [9:0] TO_TICKS = 10'(TO_CHARS * BITS_PER_CHAR * TICKS_PER_BIT);
   localparam logic [5:0] DE_HOLD_TICKS = 6'(TICKS_PER_BIT * 3 / 2);
   // driver enable sequencer states
   typedef enum logic [2:0] {
      DE_IDLE  = 3'b001,
      DE_DRIVE = 3'b010,
      DE_HOLD  = 3'b100
   } usf_de_state_t;
   // configuration bits from the port configuration register
   typedef struct packed {
      logic       nine_bit_en;
      logic       auto_driver_enable;
      logic       auto_driver_polarity_cfg;
      logic [1:0] clock_predivider_cfg;
   } usf_cfg_t;
   // line status events from the receiver
   typedef struct packed {
      logic overrun_flag;
      logic parity_err_flag;
      logic framing_err_flag;
      logic break_flag;
   } usf_lsev_t;
endpackage

// ===== usf_line_model.sv
// far-side model: transmitter word sink and modem pin driver
`timescale 1ns/1ps
module usf_line_model (
   input  wire logic       clk,        // clock
   input  wire logic       rst_n,      // async reset, active low
   input  wire logic       stall,      // refuse words while high
   input  wire logic [3:0] pins_cmd,   // dcd ri dsr cts levels
   input  wire logic       tx_valid,   // word offered
   input  wire logic [7:0] tx_data,    // offered word
   output logic            tx_ready,   // word taken this cycle
   output logic            start_edge, // start to bit0 edge
   output logic            stop_done,  // end of stop bit
   output logic [3:0]      pins_n,     // modem pins
   output logic [7:0]      last_word,  // last word taken
   output logic [7:0]      word_cnt    // words taken
);
   logic [6:0] busy;
   // one character occupies the line for 100 cycles
   assign tx_ready = !stall && busy == 7'h00;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {busy, start_edge, stop_done, last_word, word_cnt} <= '0;
         pins_n <= 4'hF;
      end else begin
         pins_n <= pins_cmd;
         start_edge <= busy == 7'h62;
         stop_done <= busy == 7'h01;
         busy <= (tx_valid && tx_ready) ? 7'h64 : busy - 7'(busy != 7'h00);
         if (tx_valid && tx_ready) begin
            last_word <= tx_data;
            word_cnt <= word_cnt + 8'h01;
         end
      end
   end
endmodule // usf_line_model

// ===== tb.sv
// self-checking bench for the serial port control block
`timescale 1ns/1ps
module tb;
   import usf_pkg::*;
   logic       clk = '0, rst_n = '0, wr_stb = '0, rd_stb = '0, rx_ready_i = '0, rx_push_i = '0, stall = '0;
   logic [2:0] addr = '0;
   logic [7:0] wdata = '0, rx_data_i = '0, rdata, tx_data_o, last_word, word_cnt, v, w;
   logic [4:0] rx_level_i = '0;
   logic [3:0] pins_cmd = 4'hF, pins_n, p;
   usf_cfg_t   cfg = '0;
   usf_lsev_t  ls_ev_i = '0;
   logic       start_edge, stop_done, tx_ready, tx_valid_o, tx_buf_ready_o, dma_mode1_o, tx_fifo_rst_o, rx_pop_o;
   logic       rx_fifo_rst_o, tx_addr_byte_o, rx_addr_accept_o, baud16_tick_o, irq_o, rts_n_o, loopback_o, dtr_n_o;
   int         errors = 0, tests_run = 0, seed = 32'heeca, n;
   always #2 clk = ~clk;
   usf_ctrl i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rdata(rdata), .cfg(cfg), .rx_data_i(rx_data_i), .rx_level_i(rx_level_i), .rx_ready_i(rx_ready_i),
      .rx_push_i(rx_push_i), .line_status_i(8'h60), .ls_ev_i(ls_ev_i), .tx_start_edge_i(start_edge),
      .tx_stop_done_i(stop_done), .tx_ready_i(tx_ready), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
      .tx_buf_ready_o(tx_buf_ready_o), .tx_fifo_rst_o(tx_fifo_rst_o), .rx_fifo_rst_o(rx_fifo_rst_o),
      .dma_mode1_o(dma_mode1_o), .tx_addr_byte_o(tx_addr_byte_o), .rx_addr_accept_o(rx_addr_accept_o),
      .baud16_tick_o(baud16_tick_o), .loopback_o(loopback_o), .irq_o(irq_o), .dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o),
      .rx_pop_o(rx_pop_o), .dcd_n(pins_n[3]), .ri_n(pins_n[2]), .dsr_n(pins_n[1]), .cts_n(pins_n[0]));
   usf_line_model i_line (.clk(clk), .rst_n(rst_n), .stall(stall), .pins_cmd(pins_cmd), .tx_valid(tx_valid_o),
      .tx_data(tx_data_o), .tx_ready(tx_ready), .start_edge(start_edge), .stop_done(stop_done),
      .pins_n(pins_n), .last_word(last_word), .word_cnt(word_cnt));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask
   // read data is taken one edge after it settled
   task automatic rdchk(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(posedge clk);
      chk(rdata & m, e);
   endtask
   task automatic wait_cnt(input logic [7:0] c, input logic [7:0] d);
      for (int k = 0; k < 300 && word_cnt !== c; k++)
         @(posedge clk);
      chk(last_word, d);
   endtask
   task automatic baud(input logic [1:0] c, input logic [7:0] d);
      n = 0;
      wr(OFS_LCR, 8'h80);
      wr(OFS_DATA, d);
      wr(OFS_IER, 8'h00);
      wr(OFS_LCR, 8'h00);
      cfg.clock_predivider_cfg <= c;
      repeat (20) @(posedge clk);
      repeat (2500) begin
         @(posedge clk);
         n += int'(baud16_tick_o === 1'b1);
      end
      d = 8'(2500 * REF_MHZ * PRE_SCALE / (CLK_MHZ * d * (c == 0 ? PRE_13_X8 : c == 1 ? PRE_1625_X8 : PRE_1_X8)));
      chk((8'(n - d + 1) < 8'h03) ? 8'h00 : 8'hFF, 8'h00);
   endtask
   task automatic close_out;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #400000;
      errors++;
      close_out();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(OFS_ISR, ISR_RST);
      rdchk(OFS_MSR, 8'h00, 8'h0F);
      v = 8'($random(seed));
      wr(OFS_SCR, v);
      rdchk(OFS_SCR, v);
      wr(OFS_IER, ~v);
      rdchk(OFS_IER, ~v & 8'hCF);
      baud(2'h0, 8'h01);
      baud(2'h1, 8'h01);
      baud(2'h3, 8'h03);
      baud(2'h2, 8'h01);
      wr(OFS_ISR, 8'h01);
      rdchk(OFS_ISR, 8'hC1);
      wr(OFS_ISR, 8'h0F);
      #1 chk({5'h0, dma_mode1_o, tx_fifo_rst_o, rx_fifo_rst_o}, 8'h03);
      @(posedge clk);
      #1 chk({5'h0, dma_mode1_o, tx_fifo_rst_o, rx_fifo_rst_o}, 8'h04);
      wr(OFS_ISR, 8'h08);
      rdchk(OFS_ISR, ISR_RST);
      chk({7'h0, dma_mode1_o}, 8'h00);
      wr(OFS_IER, 8'h01);
      for (int i = 0; i < 4; i++) begin
         wr(OFS_ISR, {2'(i), 6'h01});
         n = i == 0 ? TRIG_L0 : i == 1 ? TRIG_L1 : i == 2 ? TRIG_L2 : TRIG_L3;
         rx_level_i <= 5'(n - 1);
         rdchk(OFS_ISR, 8'hC1);
         rx_level_i <= 5'(n);
         rdchk(OFS_ISR, 8'hC4);
      end
      wr(OFS_ISR, 8'hC1);
      rx_level_i <= 5'h01;
      rx_data_i <= 8'($random(seed));
      rx_push_i <= 1'b1;
      @(posedge clk);
      rx_push_i <= 1'b0;
      repeat (6000) @(posedge clk);
      rdchk(OFS_ISR, 8'hC1);
      repeat (1000) @(posedge clk);
      rdchk(OFS_ISR, 8'hCC);
      rdchk(OFS_DATA, rx_data_i);
      chk({7'h0, rx_pop_o}, 8'h01);
      rdchk(OFS_ISR, 8'hC1);
      rx_level_i <= 5'h00;
      wr(OFS_ISR, 8'h00);
      rx_ready_i <= 1'b1;
      wr(OFS_IER, 8'h05);
      for (int i = 0; i < 4; i++) begin
         ls_ev_i <= usf_lsev_t'(4'h1 << i);
         @(posedge clk);
         ls_ev_i <= '0;
         rdchk(OFS_ISR, 8'h06);
         rdchk(OFS_LSR, 8'h60);
         rdchk(OFS_ISR, 8'h04);
      end
      wr(OFS_HCR, 8'h08);
      rdchk(OFS_ISR, 8'h04);
      chk({7'h0, irq_o}, 8'h01);
      wr(OFS_HCR, 8'h00);
      rdchk(OFS_ISR, 8'h04);
      chk({7'h0, irq_o}, 8'h00);
      wr(OFS_IER, 8'h00);
      rdchk(OFS_ISR, ISR_RST);
      rx_ready_i <= 1'b0;
      // fill the two-entry buffer while the line stalls, then drain it
      wr(OFS_IER, 8'h02);
      stall <= 1'b1;
      v = 8'($random(seed));
      w = 8'($random(seed));
      wr(OFS_DATA, v);
      wr(OFS_DATA, w);
      wr(OFS_DATA, ~v);
      chk({7'h0, tx_buf_ready_o}, 8'h00);
      stall <= 1'b0;
      wait_cnt(8'h01, v);
      wait_cnt(8'h02, w);
      repeat (200) @(posedge clk);
      chk(word_cnt, 8'h02);
      rdchk(OFS_ISR, 8'h02);
      stall <= 1'b1;
      wr(OFS_DATA, w);
      rdchk(OFS_ISR, ISR_RST);
      stall <= 1'b0;
      wait_cnt(8'h03, w);
      rdchk(OFS_ISR, 8'h02);
      rdchk(OFS_ISR, ISR_RST);
      wr(OFS_IER, 8'h00);
      cfg.auto_driver_enable <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         cfg.auto_driver_polarity_cfg <= i[0];
         repeat (400) @(posedge clk);
         chk({7'h0, rts_n_o}, {7'h0, i[0]});
         wr(OFS_DATA, v);
         wait_cnt(8'(4 + i), v);
         repeat (20) @(posedge clk);
         chk({7'h0, rts_n_o}, {7'h0, ~i[0]});
         repeat (230) @(posedge clk);
         chk({7'h0, rts_n_o}, {7'h0, ~i[0]});
         repeat (210) @(posedge clk);
         chk({7'h0, rts_n_o}, {7'h0, i[0]});
      end
      wr(OFS_IER, 8'h08);
      p = 4'hF;
      for (int i = 0; i < 8; i++) begin
         v = 8'($random(seed));
         pins_cmd <= v[3:0];
         repeat (4) @(posedge clk);
         w = {~v[3:0], p[3] ^ v[3], ~p[2] & v[2], p[1] ^ v[1], p[0] ^ v[0]};
         rdchk(OFS_ISR, {7'h0, w[3:0] == 4'h0});
         rdchk(OFS_MSR, w);
         rdchk(OFS_ISR, ISR_RST);
         p = v[3:0];
      end
      wr(OFS_IER, 8'h00);
      for (int h = 0; h < 16; h++) begin
         wr(OFS_HCR, 8'h10 | 8'(h));
         rdchk(OFS_MSR, {h[3], h[2], h[0], h[1], 4'h0}, 8'hF0);
         chk({6'h0, loopback_o, dtr_n_o}, 8'h03);
      end
      wr(OFS_HCR, 8'h00);
      for (int i = 0; i < 4; i++) begin
         cfg.nine_bit_en <= i[1];
         wr(OFS_IER, {i[0], ~i[0], 6'h00});
         repeat (2) @(posedge clk);
         chk({6'h0, tx_addr_byte_o, rx_addr_accept_o}, {6'h0, i[1] & i[0], i[1] & ~i[0]});
      end
      close_out();
   end
endmodule // tb
